// ### logic/vps_pkg.sv
// What this block does
// - Control register at 0x64, resets 0x10
// - Bits 7-4 pick fixed pattern, reset 1
// - Auto-scroll overrides the fixed selector
// - Ramps spread evenly over active width/height
// - Each code: normal colour, inverted complement
// - Codes 0000 and 1111 are reserved
// - 0001 white, 0010 black, inverted swapped
// - 0011-0101 red, green, blue, inverted CMY
// - 0110 onward horizontal ramps from black
// - 1001 onward vertical ramps from black
// - Custom code outputs three-register custom colour
// - Bit 3 selects compliance pattern, ignores selector
// - Bit 2 gives eight ordered colour bars
// - Bit 1 swaps first and third of the four colour bands
// - Bit 0 turns the generator on/off
// - Invert bit outputs complement of every pattern
// - Auto-scroll advances after programmed frame count
package vps_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_TX_CTL   = 8'h63;
    localparam logic [7:0] IDX_PG_CTL   = 8'h64;
    localparam logic [7:0] IDX_PG_CFG   = 8'h65;
    localparam logic [7:0] IDX_RED      = 8'h6A;
    localparam logic [7:0] IDX_GREEN    = 8'h6B;
    localparam logic [7:0] IDX_BLUE     = 8'h6C;
    localparam logic [7:0] IDX_FRAMES   = 8'h6D;
    localparam logic [7:0] IDX_STATUS   = 8'h6E;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] PG_CTL_RST   = 8'h10;
    localparam logic [7:0] REG_ZERO_RST = 8'h00;
    localparam logic [7:0] FRAMES_RST   = 8'h1E;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int SEL_HI         = 7;
    localparam int SEL_LO         = 4;
    localparam int BIT_COMPLIANCE = 3;
    localparam int BIT_BARS       = 2;
    localparam int BIT_BAND_REV   = 1;
    localparam int BIT_ENABLE     = 0;
    localparam int BIT_INVERT     = 1;
    localparam int BIT_SCROLL     = 0;
    localparam int BIT_TX_PWDN    = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [3:0] {
        SEL_RSVD_LO = 4'h0,
        SEL_WHITE   = 4'h1,
        SEL_BLACK   = 4'h2,
        SEL_RED     = 4'h3,
        SEL_GREEN   = 4'h4,
        SEL_BLUE    = 4'h5,
        SEL_HRAMP_W = 4'h6,
        SEL_HRAMP_R = 4'h7,
        SEL_HRAMP_G = 4'h8,
        SEL_VRAMP_W = 4'h9,
        SEL_VRAMP_X = 4'hA,
        SEL_VRAMP_R = 4'hB,
        SEL_VRAMP_G = 4'hC,
        SEL_VRAMP_B = 4'hD,
        SEL_CUSTOM  = 4'hE,
        SEL_RSVD_HI = 4'hF
    } vps_sel_e;

    typedef enum logic [0:0] {
        WB_IDLE = 1'b0,
        WB_ACK  = 1'b1
    } vps_wb_e;

    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
    } vps_rgb_s;

    // Three-bit channel mask to full-level colour
    function automatic vps_rgb_s vps_mask_rgb(input logic [2:0] mask);
        vps_rgb_s c;
        c.red   = {8{mask[2]}};
        c.green = {8{mask[1]}};
        c.blue  = {8{mask[0]}};
        return c;
    endfunction

endpackage

// ### logic/vps_ramp_scale.sv
module vps_ramp_scale
    import vps_pkg::*;
#(
    parameter int ACTIVE = 1920,
    parameter int POS_W  = 12
) (
    // Position inside the active region
    input  wire logic [POS_W-1:0] i_pos,
    // Brightness step
    output logic      [7:0]       o_level
);
    localparam logic [POS_W+7:0] DIVISOR = (POS_W+8)'(ACTIVE);

    logic [POS_W+7:0] quot;

    // Even spread of 256 steps over the active span
    assign quot    = {i_pos, 8'h00} / DIVISOR;
    assign o_level = (|quot[POS_W+7:8]) ? 8'hFF : quot[7:0];
endmodule

// ### logic/vps_color_lut.sv
module vps_color_lut
    import vps_pkg::*;
(
    // Selector and ramp levels
    input  wire vps_sel_e   i_code,
    input  wire logic [7:0] i_hlevel,
    input  wire logic [7:0] i_vlevel,
    input  wire vps_rgb_s   i_custom,
    // Non-inverted colour
    output vps_rgb_s        o_rgb
);
    always_comb begin
        o_rgb = '0;
        case (i_code)
            SEL_WHITE:   o_rgb = vps_mask_rgb(3'b111);
            SEL_BLACK:   o_rgb = '0;
            SEL_RED:     o_rgb = vps_mask_rgb(3'b100);
            SEL_GREEN:   o_rgb = vps_mask_rgb(3'b010);
            SEL_BLUE:    o_rgb = vps_mask_rgb(3'b001);
            SEL_HRAMP_W: o_rgb = {i_hlevel, i_hlevel, i_hlevel};
            SEL_HRAMP_R: o_rgb = {i_hlevel, 8'h00, 8'h00};
            SEL_HRAMP_G: o_rgb = {8'h00, i_hlevel, 8'h00};
            SEL_VRAMP_W,
            SEL_VRAMP_X: o_rgb = {i_vlevel, i_vlevel, i_vlevel};
            SEL_VRAMP_R: o_rgb = {i_vlevel, 8'h00, 8'h00};
            SEL_VRAMP_G: o_rgb = {8'h00, i_vlevel, 8'h00};
            SEL_VRAMP_B: o_rgb = {8'h00, 8'h00, i_vlevel};
            SEL_CUSTOM:  o_rgb = i_custom;
            // Reserved codes give plain black
            default:     o_rgb = '0;
        endcase
    end
endmodule

// ### logic/vps_pattern_select.sv
// The Wishbone interface to the registers is this design's own decision.
module vps_pattern_select
    import vps_pkg::*;
#(
    parameter int H_ACTIVE = 1920,
    parameter int V_ACTIVE = 1080,
    parameter int POS_W    = 12
) (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    // Wishbone slave
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [31:0] i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    // Video timing in
    input  wire logic        i_frame_start,
    input  wire logic        i_de,
    // Pattern out
    output vps_rgb_s         o_pixel,
    output logic             o_pixel_valid,
    output logic             o_pattern_active,
    output logic             o_loopthrough_tx_powerdown
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers and state
    vps_wb_e          wb_state_r;
    logic [7:0]       tx_ctl_r;
    logic [7:0]       pg_ctl_r;
    logic [7:0]       pg_cfg_r;
    vps_rgb_s         custom_r;
    logic [7:0]       frames_r;
    logic [7:0]       frame_cnt_r;
    vps_sel_e         scroll_sel_r;
    logic [POS_W-1:0] hpos_r;
    logic [POS_W-1:0] vpos_r;
    logic             de_d_r;

    logic             wb_req;
    logic             wb_wr;
    logic             adr_ok;
    logic [7:0]       reg_idx;
    logic [7:0]       rd_val;
    logic [7:0]       wr_byte;
    logic             gen_en;
    logic             invert_colors;
    logic             auto_scroll_enable;
    logic             scroll_step;
    vps_sel_e         fixed_pattern_select;
    vps_sel_e         eff_sel;
    logic [7:0]       hlevel;
    logic [7:0]       vlevel;
    vps_rgb_s         lut_rgb;
    vps_rgb_s         pat_rgb;
    logic [2:0]       bar_mask;
    logic [2:0]       band_mask;

    assign gen_en               = pg_ctl_r[BIT_ENABLE];
    assign invert_colors        = pg_cfg_r[BIT_INVERT];
    assign auto_scroll_enable   = pg_cfg_r[BIT_SCROLL];
    assign fixed_pattern_select = vps_sel_e'(pg_ctl_r[SEL_HI:SEL_LO]);

    ////////////////////////////////////////////////////////////////////////////
    // Wishbone slave: one wait state, ack for one cycle
    assign wb_req  = i_wb_cyc && i_wb_stb;
    assign reg_idx = i_wb_adr[9:2];
    assign adr_ok  = (i_wb_adr[31:10] == 22'h00_0000) && (i_wb_adr[1:0] == 2'b00);
    assign wb_wr   = (wb_state_r == WB_ACK) && wb_req && i_wb_we && i_wb_sel[0] && adr_ok;
    assign wr_byte = i_wb_dat[7:0];
    assign o_wb_ack = (wb_state_r == WB_ACK);

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            wb_state_r <= WB_IDLE;
        end else begin
            case (wb_state_r)
                WB_IDLE: wb_state_r <= wb_req ? WB_ACK : WB_IDLE;
                WB_ACK:  wb_state_r <= WB_IDLE;
                default: wb_state_r <= WB_IDLE;
            endcase
        end
    end

    always_comb begin
        rd_val = 8'h00;
        if (adr_ok) begin
            case (reg_idx)
                IDX_TX_CTL: rd_val = tx_ctl_r;
                IDX_PG_CTL: rd_val = pg_ctl_r;
                IDX_PG_CFG: rd_val = pg_cfg_r;
                IDX_RED:    rd_val = custom_r.red;
                IDX_GREEN:  rd_val = custom_r.green;
                IDX_BLUE:   rd_val = custom_r.blue;
                IDX_FRAMES: rd_val = frames_r;
                IDX_STATUS: rd_val = {eff_sel, 3'b000, gen_en};
                default:    rd_val = 8'h00;
            endcase
        end
    end

    // Read data captured as ack rises; unmapped reads give zero
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_wb_dat <= 32'h0000_0000;
        end else if (wb_state_r == WB_IDLE && wb_req) begin
            o_wb_dat <= {24'h00_0000, rd_val};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software registers; writes land on the ack edge
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            tx_ctl_r <= REG_ZERO_RST;
            pg_ctl_r <= PG_CTL_RST;
            pg_cfg_r <= REG_ZERO_RST;
            custom_r <= '0;
            frames_r <= FRAMES_RST;
        end else if (wb_wr) begin
            case (reg_idx)
                IDX_TX_CTL: tx_ctl_r <= {7'h00, wr_byte[BIT_TX_PWDN]};
                IDX_PG_CTL: pg_ctl_r <= wr_byte;
                IDX_PG_CFG: pg_cfg_r <= {6'h00, wr_byte[BIT_INVERT:BIT_SCROLL]};
                IDX_RED:    custom_r.red   <= wr_byte;
                IDX_GREEN:  custom_r.green <= wr_byte;
                IDX_BLUE:   custom_r.blue  <= wr_byte;
                IDX_FRAMES: frames_r <= wr_byte;
                default:    ;
            endcase
        end
    end

    // Driver power-down is left to software ordering, not enforced
    assign o_loopthrough_tx_powerdown = tx_ctl_r[BIT_TX_PWDN];

    ////////////////////////////////////////////////////////////////////////////
    // Active-region position
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            hpos_r <= '0;
            vpos_r <= '0;
            de_d_r <= 1'b0;
        end else begin
            de_d_r <= i_de;
            if (i_frame_start) begin
                hpos_r <= '0;
                vpos_r <= '0;
            end else if (i_de) begin
                hpos_r <= hpos_r + 1'b1;
            end else if (de_d_r) begin
                hpos_r <= '0;
                vpos_r <= vpos_r + 1'b1;
            end
        end
    end

    vps_ramp_scale #(
        .ACTIVE (H_ACTIVE),
        .POS_W  (POS_W)
    ) u_hscale (
        .i_pos   (hpos_r),
        .o_level (hlevel)
    );

    vps_ramp_scale #(
        .ACTIVE (V_ACTIVE),
        .POS_W  (POS_W)
    ) u_vscale (
        .i_pos   (vpos_r),
        .o_level (vlevel)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Auto-scroll through the defined codes only
    assign scroll_step = gen_en && auto_scroll_enable && i_frame_start
                         && (frame_cnt_r >= frames_r);

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            frame_cnt_r  <= 8'h00;
            scroll_sel_r <= SEL_WHITE;
        end else if (!auto_scroll_enable || !gen_en) begin
            frame_cnt_r  <= 8'h00;
        end else if (scroll_step) begin
            frame_cnt_r  <= 8'h00;
            // Wrap skips both reserved codes
            scroll_sel_r <= (scroll_sel_r == SEL_CUSTOM) ? SEL_WHITE
                          : vps_sel_e'(scroll_sel_r + 4'h1);
        end else if (i_frame_start) begin
            frame_cnt_r  <= frame_cnt_r + 8'h01;
        end
    end

    assign eff_sel = auto_scroll_enable ? scroll_sel_r : fixed_pattern_select;

    vps_color_lut u_lut (
        .i_code   (eff_sel),
        .i_hlevel (hlevel),
        .i_vlevel (vlevel),
        .i_custom (custom_r),
        .o_rgb    (lut_rgb)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Pattern sources and priority
    always_comb begin
        case (hlevel[7:5])
            3'd0:    bar_mask = 3'b111;
            3'd1:    bar_mask = 3'b110;
            3'd2:    bar_mask = 3'b011;
            3'd3:    bar_mask = 3'b010;
            3'd4:    bar_mask = 3'b101;
            3'd5:    bar_mask = 3'b100;
            3'd6:    bar_mask = 3'b001;
            default: bar_mask = 3'b000;
        endcase
    end

    // Four bands top to bottom; reversal swaps first and third
    always_comb begin
        case (vlevel[7:6])
            2'd0:    band_mask = pg_ctl_r[BIT_BAND_REV] ? 3'b001 : 3'b110;
            2'd1:    band_mask = 3'b011;
            2'd2:    band_mask = pg_ctl_r[BIT_BAND_REV] ? 3'b110 : 3'b001;
            default: band_mask = 3'b100;
        endcase
    end

    always_comb begin
        if (pg_ctl_r[BIT_COMPLIANCE]) begin
            pat_rgb = vps_mask_rgb(band_mask);
        end else if (pg_ctl_r[BIT_BARS]) begin
            pat_rgb = vps_mask_rgb(bar_mask);
        end else begin
            pat_rgb = lut_rgb;
        end
    end

    // One register stage; inversion as the last step keeps every pattern paired
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_pixel          <= '0;
            o_pixel_valid    <= 1'b0;
            o_pattern_active <= 1'b0;
        end else begin
            o_pattern_active <= gen_en;
            o_pixel_valid    <= gen_en && i_de;
            if (!gen_en || !i_de) begin
                o_pixel <= '0;
            end else begin
                o_pixel <= invert_colors ? ~pat_rgb : pat_rgb;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    logic plain_fixed;
    assign plain_fixed = gen_en && i_de && !pg_ctl_r[BIT_COMPLIANCE]
                         && !pg_ctl_r[BIT_BARS] && !auto_scroll_enable;

    property p_ctl_reset;
        @(posedge i_clk) disable iff (1'b0) !i_resetn |=> pg_ctl_r == PG_CTL_RST;
    endproperty
    a_ctl_reset: assert property (p_ctl_reset) else $error("control reset value wrong");

    sequence s_req_idle;
        wb_req && !o_wb_ack;
    endsequence
    sequence s_ack_pulse;
        o_wb_ack ##1 !o_wb_ack;
    endsequence
    property p_ack_once;
        s_req_idle |=> s_ack_pulse;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("bus ack not a single pulse");

    property p_ctl_write;
        wb_wr && reg_idx == IDX_PG_CTL |=> pg_ctl_r == $past(wr_byte);
    endproperty
    a_ctl_write: assert property (p_ctl_write) else $error("control write lost");

    property p_off_quiet;
        !gen_en |=> !o_pattern_active && !o_pixel_valid && o_pixel == '0;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("output while disabled");

    property p_white_inv;
        plain_fixed && fixed_pattern_select == SEL_WHITE && invert_colors |=> o_pixel == '0;
    endproperty
    a_white_inv: assert property (p_white_inv) else $error("inverted white not black");

    property p_red;
        plain_fixed && fixed_pattern_select == SEL_RED && !invert_colors
            |=> o_pixel == vps_mask_rgb(3'b100);
    endproperty
    a_red: assert property (p_red) else $error("solid red wrong");

    property p_bars_first;
        gen_en && i_de && !pg_ctl_r[BIT_COMPLIANCE] && pg_ctl_r[BIT_BARS]
            && !invert_colors && hpos_r == '0 |=> o_pixel == vps_mask_rgb(3'b111);
    endproperty
    a_bars_first: assert property (p_bars_first) else $error("first bar not white");

    property p_band_rev;
        gen_en && i_de && pg_ctl_r[BIT_COMPLIANCE] && pg_ctl_r[BIT_BAND_REV]
            && !invert_colors && vpos_r == '0 |=> o_pixel == vps_mask_rgb(3'b001);
    endproperty
    a_band_rev: assert property (p_band_rev) else $error("reversed band not blue");

    property p_scroll_step;
        scroll_step && scroll_sel_r != SEL_CUSTOM |=> scroll_sel_r == $past(scroll_sel_r) + 4'h1;
    endproperty
    a_scroll_step: assert property (p_scroll_step) else $error("scroll stalled");

    property p_scroll_hold;
        !auto_scroll_enable |=> $stable(scroll_sel_r);
    endproperty
    a_scroll_hold: assert property (p_scroll_hold) else $error("pattern moved");

endmodule

// ### dv/video_test_pattern_select_test.sv
module video_test_pattern_select_test
    import vps_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    ////////////////////////////////////////////////////////////////////////////
    // Small active area keeps every pixel of a frame checkable
    localparam int         H_ACT     = 16;
    localparam int         V_ACT     = 16;
    localparam logic [2:0] BAR_T [8] = '{3'h7, 3'h6, 3'h3, 3'h2, 3'h5, 3'h4, 3'h1, 3'h0};
    localparam logic [2:0] BAND_T[4] = '{3'h6, 3'h3, 3'h1, 3'h4};
    localparam logic [2:0] REV_T [4] = '{3'h1, 3'h3, 3'h6, 3'h4};

    logic        i_clk;
    logic        i_resetn;
    logic        i_wb_cyc;
    logic        i_wb_stb;
    logic        i_wb_we;
    logic [31:0] i_wb_adr;
    logic [3:0]  i_wb_sel;
    logic [31:0] i_wb_dat;
    logic [31:0] o_wb_dat;
    logic        o_wb_ack;
    logic        i_frame_start;
    logic        i_de;
    vps_rgb_s    o_pixel;
    logic        o_pixel_valid;
    logic        o_pattern_active;
    logic        o_loopthrough_tx_powerdown;
    int          errors;
    int          comparisons;
    int          n;
    logic [7:0]  m_reg [256];
    logic [3:0]  m_scr;
    logic        pend_v;
    logic [23:0] pend_p;
    logic [31:0] seed;
    logic [31:0] q;

    vps_pattern_select #(.H_ACTIVE(H_ACT), .V_ACTIVE(V_ACT), .POS_W(12)) dut_u (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
        .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
        .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_frame_start(i_frame_start),
        .i_de(i_de), .o_pixel(o_pixel), .o_pixel_valid(o_pixel_valid),
        .o_pattern_active(o_pattern_active),
        .o_loopthrough_tx_powerdown(o_loopthrough_tx_powerdown)
    );

    always #12.5 i_clk = ~i_clk;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic bit mapped(input logic [7:0] idx);
        return idx inside {IDX_TX_CTL, IDX_PG_CTL, IDX_PG_CFG, IDX_RED, IDX_GREEN,
                           IDX_BLUE, IDX_FRAMES};
    endfunction

    function automatic logic [7:0] m_read(input logic [7:0] idx);
        logic [3:0] eff;
        eff = m_reg[IDX_PG_CFG][0] ? m_scr : m_reg[IDX_PG_CTL][7:4];
        return (idx == IDX_STATUS) ? {eff, 3'h0, m_reg[IDX_PG_CTL][0]} : m_reg[idx];
    endfunction

    function automatic logic [23:0] msk(input logic [2:0] m);
        return {{8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
    endfunction

    function automatic logic [23:0] model_pix(input int x, input int y);
        int          h;
        int          v;
        logic [7:0]  c;
        logic [23:0] p;
        h = (x * 256 / H_ACT > 255) ? 255 : x * 256 / H_ACT;
        v = (y * 256 / V_ACT > 255) ? 255 : y * 256 / V_ACT;
        c = m_reg[IDX_PG_CTL];
        if (c[3]) p = msk(c[1] ? REV_T[v / 64] : BAND_T[v / 64]);
        else if (c[2]) p = msk(BAR_T[h / 32]);
        else begin
            case (c[7:4])
                4'h1: p = msk(3'h7);
                4'h3: p = msk(3'h4);
                4'h4: p = msk(3'h2);
                4'h5: p = msk(3'h1);
                4'h6: p = {3{h[7:0]}};
                4'h7: p = {h[7:0], 16'h0000};
                4'h8: p = {8'h00, h[7:0], 8'h00};
                4'h9, 4'hA: p = {3{v[7:0]}};
                4'hB: p = {v[7:0], 16'h0000};
                4'hC: p = {8'h00, v[7:0], 8'h00};
                4'hD: p = {16'h0000, v[7:0]};
                4'hE: p = {m_reg[IDX_RED], m_reg[IDX_GREEN], m_reg[IDX_BLUE]};
                default: p = 24'h00_0000;
            endcase
        end
        return m_reg[IDX_PG_CFG][1] ? ~p : p;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_of_test;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Enable reaches the output one edge after the write lands
    task automatic chk_active(input logic e);
        @(negedge i_clk);
        @(negedge i_clk);
        check("active", {31'h0, e}, {31'h0, o_pattern_active});
    endtask

    task automatic m_reset;
        foreach (m_reg[i]) m_reg[i] = 8'h00;
        m_reg[IDX_PG_CTL] = 8'h10;
        m_reg[IDX_FRAMES] = FRAMES_RST;
        m_scr = 4'h1;
        pend_v = 1'b0;
        pend_p = 24'h00_0000;
    endtask

    // No cycle count assumed for ack; the wait ends on ack or at the 20-cycle bound
    task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] d,
                      input logic [3:0] s);
        int k;
        @(posedge i_clk);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we  <= we;
        i_wb_adr <= {22'h0, idx, 2'h0};
        i_wb_sel <= s;
        i_wb_dat <= {24'h00_0000, d};
        k = 0;
        do begin
            @(posedge i_clk);
            k++;
        end while (o_wb_ack !== 1'b1 && k < 20);
        q = o_wb_dat;
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
        i_wb_we  <= 1'b0;
        if (k >= 20) begin
            check("bus_ack", 32'h1, 32'h0);
            end_of_test();
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] s = 4'hF);
        wb(1'b1, idx, d, s);
        if (s[0] && mapped(idx)) m_reg[idx] = d;
    endtask

    task automatic rd(input logic [7:0] idx);
        wb(1'b0, idx, 8'h00, 4'hF);
        check($sformatf("reg %h", idx), {24'h00_0000, m_read(idx)}, q);
    endtask

    // Output of the pixel driven one edge earlier is settled at the falling edge
    task automatic step(input logic fs, input logic de, input int x, input int y);
        @(posedge i_clk);
        i_frame_start <= fs;
        i_de          <= de;
        @(negedge i_clk);
        check("pixel_valid", {31'h0, pend_v}, {31'h0, o_pixel_valid});
        check("pixel", {8'h00, pend_p}, {8'h00, o_pixel});
        pend_v = de && m_reg[IDX_PG_CTL][0];
        pend_p = pend_v ? model_pix(x, y) : 24'h00_0000;
    endtask

    task automatic frame;
        step(1'b1, 1'b0, 0, 0);
        for (int y = 0; y < V_ACT; y++) begin
            for (int x = 0; x < H_ACT; x++) step(1'b0, 1'b1, x, y);
            step(1'b0, 1'b0, 0, 0);
        end
    endtask

    task automatic reset_check;
        for (int i = 8'h63; i <= 8'h6E; i++) rd(i[7:0]);
        check("active", 32'h0, {31'h0, o_pattern_active});
        check("powerdown", 32'h0, {31'h0, o_loopthrough_tx_powerdown});
        $display("test reset done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        i_clk = 1'b0;
        i_resetn = 1'b0;
        i_wb_cyc = 1'b0;
        i_wb_stb = 1'b0;
        i_wb_we = 1'b0;
        i_wb_adr = 32'h0000_0000;
        i_wb_sel = 4'h0;
        i_wb_dat = 32'h0000_0000;
        i_frame_start = 1'b0;
        i_de = 1'b0;
        errors = 0;
        comparisons = 0;
        seed = 32'h9707_84c5;
        m_reset();
        repeat (16) @(posedge i_clk);
        i_resetn <= 1'b1;
        reset_check();
        wr(IDX_PG_CTL, 8'hFF, 4'hE);
        wr(8'h70, 8'hA5);
        rd(IDX_PG_CTL);
        rd(8'h70);
        $display("test bus refusal done");
        // Driver goes down before the generator is ever enabled
        wr(IDX_TX_CTL, 8'h01);
        rd(IDX_TX_CTL);
        check("powerdown", 32'h1, {31'h0, o_loopthrough_tx_powerdown});
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            wr(IDX_RED + i[7:0], seed[7:0]);
        end
        for (int inv = 0; inv < 2; inv++) begin
            wr(IDX_PG_CFG, {6'h0, inv[0], 1'b0});
            for (int c = 0; c < 16; c++) begin
                wr(IDX_PG_CTL, {c[3:0], 4'h1});
                chk_active(1'b1);
                frame();
            end
            foreach (BAR_T[i]) if (i < 5) begin
                seed = lfsr(seed);
                wr(IDX_PG_CTL, {seed[3:0], 4'h5 + i[3:0] * 4'h2});
                frame();
            end
        end
        $display("test patterns done");
        wr(IDX_PG_CTL, 8'h30);
        chk_active(1'b0);
        frame();
        $display("test disable done");
        wr(IDX_FRAMES, 8'h02);
        wr(IDX_PG_CTL, 8'h51);
        wr(IDX_PG_CFG, 8'h01);
        rd(IDX_STATUS);
        n = 0;
        do begin
            step(1'b1, 1'b0, 0, 0);
            step(1'b0, 1'b0, 0, 0);
            n++;
            wb(1'b0, IDX_STATUS, 8'h00, 4'hF);
        end while (q[7:4] == 4'h1 && n < 8);
        check("scroll_sel", 32'h2, {28'h0, q[7:4]});
        check("scroll_frames", 32'h1, {31'h0, n >= 2 && n <= 3});
        m_scr = 4'h2;
        wr(IDX_PG_CFG, 8'h00);
        repeat (4) begin
            step(1'b1, 1'b0, 0, 0);
            step(1'b0, 1'b0, 0, 0);
        end
        rd(IDX_STATUS);
        // Scroll position held while off, shown again once back on
        wr(IDX_PG_CFG, 8'h01);
        rd(IDX_STATUS);
        $display("test scroll done");
        // Second reset in mid-run must restore every register
        @(posedge i_clk);
        i_resetn <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_resetn <= 1'b1;
        m_reset();
        reset_check();
        end_of_test();
    end
endmodule
